// ===== core/ehcii_top.sv
`timescale 1ns/10ps
// Function
// - Enabled active status flag raises host interrupt.
// - Disabled sources still flag status for polling.
// - Bit 5 gates async advance, at threshold.
// - Bit 4 gates system error, immediately.
// - Bit 3 gates frame rollover, immediately.
// - Bit 2 gates port change, immediately.
// - Bit 1 gates transfer error, at threshold.
// - Bit 0 gates transfer done, at threshold.
// - Enable register at 28h, bits 5-0, reset zero.
// - Index updates every 125 us while running.
// - Index bits N to 3 select list entry.
// - Index writes accepted only while halted.
// - Index write changes following start-of-frame numbers.
// - N is 12, 11 or 10 by size.
// - Start-of-frame number is index bits 13 to 3.
// - Index increments by one each microframe.
// - Rollover flag set when list index wraps.
module ehcii_top import ehcii_pkg::*; #(
  parameter int MICROFRAME_LEN = MICROFRAME_CYCLES
) (
  input wire logic ref_clk, // System clock, 125 MHz.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic [7:0] reg_addr, // Register byte offset.
  input wire logic reg_write, // Register write strobe.
  input wire logic reg_read, // Register read strobe.
  input wire logic [3:0] reg_byte_en, // Write byte lanes.
  input wire logic [31:0] reg_wdata, // Write data.
  output logic [31:0] reg_rdata, // Read data, registered.
  output logic reg_read_ack, // Read data valid pulse.
  input wire logic [5:0] status_flags, // Status flags from the status register.
  input wire logic halted_flag, // Controller halted.
  input wire logic run_stop, // Run command.
  input wire logic [1:0] frame_list_size, // Frame list size code.
  input wire logic threshold_tick, // Interrupt threshold reached, pulse.
  output logic host_irq, // Interrupt to the host, level.
  output logic rollover_set, // Sets the rollover status flag, pulse.
  output logic microframe_tick, // Start of a new microframe, pulse.
  output logic [10:0] sof_frame_number, // Frame number for start-of-frame.
  output logic [9:0] frame_list_entry // Current frame list entry.
);

  typedef struct packed {
    logic [5:0] irq_en;
    logic thr_armed;
    logic irq;
    logic [31:0] rdata;
    logic read_ack;
  } ehcii_state_type;

  ehcii_state_type state;
  ehcii_state_type next_state;
  logic [5:0] active;
  logic imm_active;
  logic thr_active;
  logic index_write;
  logic [9:0] entry_mask;

  ehcii_frame_if frame ();

  ehcii_frame_counter #(
    .CYCLES(MICROFRAME_LEN)
  ) u_counter (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .frame(frame)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt gating.
  always_comb begin
    active = status_flags & state.irq_en;
    imm_active = |(active & IMMEDIATE_SOURCES);
    thr_active = |(active & THRESHOLD_SOURCES);
  end

  // Index loads only on full-word writes while halted.
  assign index_write = reg_write && reg_addr == FRAME_INDEX_OFFSET
    && reg_byte_en == FULL_WORD_BYTES && halted_flag;
  assign frame.load = index_write;
  assign frame.load_value = reg_wdata[INDEX_WIDTH-1:0];
  assign frame.run = run_stop && !halted_flag;
  assign frame.size = frame_list_size;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    next_state.read_ack = reg_read;
    if (reg_write && reg_addr == IRQ_ENABLE_OFFSET && reg_byte_en[0]) begin
      next_state.irq_en = reg_wdata[ENABLE_WIDTH-1:0];
    end
    // The arm drops once software clears every enabled threshold source.
    if (!thr_active) begin
      next_state.thr_armed = 1'b0;
    end else if (threshold_tick) begin
      next_state.thr_armed = 1'b1;
    end
    next_state.irq = imm_active || (thr_active && (state.thr_armed || threshold_tick));
    if (reg_read) begin
      unique case (reg_addr)
        IRQ_ENABLE_OFFSET: next_state.rdata = {26'h0000000, state.irq_en};
        FRAME_INDEX_OFFSET: next_state.rdata = {18'h00000, frame.index};
        default: next_state.rdata = UNMAPPED_READ_VALUE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    unique case (ehcii_list_size_type'(frame_list_size))
      ehcii_size_512: entry_mask = ENTRY_MASK_512;
      ehcii_size_256: entry_mask = ENTRY_MASK_256;
      default: entry_mask = ENTRY_MASK_1024;
    endcase
  end

  assign frame_list_entry = frame.index[ENTRY_LSB +: ENTRY_WIDTH] & entry_mask;
  assign sof_frame_number = frame.index[ENTRY_LSB +: SOF_WIDTH];
  assign rollover_set = frame.rollover;
  assign microframe_tick = frame.tick;
  assign host_irq = state.irq;
  assign reg_rdata = state.rdata;
  assign reg_read_ack = state.read_ack;

  ////////////////////////////////////////////////////////////////////////////
  a_irq_immediate: assert property (@(posedge ref_clk) disable iff (!reset_n)
    |(status_flags & state.irq_en & IMMEDIATE_SOURCES) |=> host_irq)
    else $error("Immediate source did not raise the interrupt.");

  a_irq_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (status_flags & state.irq_en) == 6'h00 |=> !host_irq)
    else $error("Interrupt raised with no enabled active flag.");

  a_thr_wait: assert property (@(posedge ref_clk) disable iff (!reset_n)
    thr_active && !imm_active && !state.thr_armed && !threshold_tick |=> !host_irq)
    else $error("Threshold source interrupted before the threshold.");

  a_thr_fire: assert property (@(posedge ref_clk) disable iff (!reset_n)
    thr_active && threshold_tick ##1 thr_active |-> host_irq ##1 (!thr_active || host_irq))
    else $error("Threshold interrupt not raised or not held.");

  a_index_locked: assert property (@(posedge ref_clk) disable iff (!reset_n)
    reg_write && reg_addr == FRAME_INDEX_OFFSET && !halted_flag && !frame.run
    |=> $stable(frame.index))
    else $error("Index written while not halted.");

  a_enable_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
    reg_write && reg_addr == IRQ_ENABLE_OFFSET && reg_byte_en[0]
    |=> state.irq_en == $past(reg_wdata[ENABLE_WIDTH-1:0]))
    else $error("Enable register write was not stored.");

endmodule // ehcii_top

// ===== shared/ehcii_pkg.sv
package ehcii_pkg;

  localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h28;
  localparam logic [7:0] FRAME_INDEX_OFFSET = 8'h2C;
  localparam logic [31:0] REG_RESET_VALUE = 32'h00000000;
  localparam logic [31:0] UNMAPPED_READ_VALUE = 32'h00000000;
  localparam logic [3:0] FULL_WORD_BYTES = 4'hF;

  localparam int ENABLE_WIDTH = 6;
  localparam int INDEX_WIDTH = 14;
  localparam int CNT_WIDTH = 16;
  localparam int SOF_WIDTH = 11;
  localparam int ENTRY_WIDTH = 10;
  localparam int ENTRY_LSB = 3;

  // Enable and status bit positions.
  localparam int ASYNC_ADVANCE_BIT = 5;
  localparam int SYSTEM_ERROR_BIT = 4;
  localparam int ROLLOVER_BIT = 3;
  localparam int PORT_CHANGE_BIT = 2;
  localparam int TRANSFER_ERROR_BIT = 1;
  localparam int TRANSFER_DONE_BIT = 0;

  // Sources that wait for the interrupt threshold, and those that do not.
  localparam logic [5:0] THRESHOLD_SOURCES = 6'h23;
  localparam logic [5:0] IMMEDIATE_SOURCES = 6'h1C;

  localparam logic [13:0] INDEX_ONE = 14'h0001;
  localparam logic [15:0] CNT_ONE = 16'h0001;

  typedef enum logic [1:0] {
    ehcii_size_1024 = 2'h0,
    ehcii_size_512 = 2'h1,
    ehcii_size_256 = 2'h2,
    ehcii_size_reserved = 2'h3
  } ehcii_list_size_type;

  // Highest index bit of the list pointer for each size.
  localparam int TOP_BIT_1024 = 12;
  localparam int TOP_BIT_512 = 11;
  localparam int TOP_BIT_256 = 10;
  localparam logic [9:0] ENTRY_MASK_1024 = 10'h3FF;
  localparam logic [9:0] ENTRY_MASK_512 = 10'h1FF;
  localparam logic [9:0] ENTRY_MASK_256 = 10'h0FF;

  localparam int MICROFRAME_US = 125;
  localparam int CLOCK_MHZ = 125;
  localparam int MICROFRAME_CYCLES = MICROFRAME_US * CLOCK_MHZ;

endpackage

// ===== shared/ehcii_frame_if.sv
`timescale 1ns/10ps
interface ehcii_frame_if;
  logic run;
  logic load;
  logic [13:0] load_value;
  logic [1:0] size;
  logic [13:0] index;
  logic tick;
  logic rollover;

  modport counter (
    input run,
    input load,
    input load_value,
    input size,
    output index,
    output tick,
    output rollover
  );

  modport ctrl (
    output run,
    output load,
    output load_value,
    output size,
    input index,
    input tick,
    input rollover
  );
endinterface

// ===== core/ehcii_frame_counter.sv
`timescale 1ns/10ps
module ehcii_frame_counter import ehcii_pkg::*; #(
  parameter int CYCLES = MICROFRAME_CYCLES
) (
  input wire logic ref_clk, // System clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  ehcii_frame_if.counter frame // Index control and results.
);

  typedef struct packed {
    logic [15:0] cycle_cnt;
    logic [13:0] index;
    logic tick;
    logic rollover;
  } ehcii_cnt_state_type;

  ehcii_cnt_state_type state;
  ehcii_cnt_state_type next_state;
  int wrap_bit;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    next_state.tick = 1'b0;
    next_state.rollover = 1'b0;
    unique case (ehcii_list_size_type'(frame.size))
      ehcii_size_512: wrap_bit = TOP_BIT_512 + 1;
      ehcii_size_256: wrap_bit = TOP_BIT_256 + 1;
      default: wrap_bit = TOP_BIT_1024 + 1;
    endcase
    if (frame.load) begin
      next_state.index = frame.load_value;
      next_state.cycle_cnt = '0;
    end else if (frame.run) begin
      if (state.cycle_cnt == CNT_WIDTH'(CYCLES - 1)) begin
        next_state.cycle_cnt = '0;
        next_state.index = state.index + INDEX_ONE;
        next_state.tick = 1'b1;
        next_state.rollover = next_state.index[wrap_bit] != state.index[wrap_bit];
      end else begin
        next_state.cycle_cnt = state.cycle_cnt + CNT_ONE;
      end
    end else begin
      next_state.cycle_cnt = '0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign frame.index = state.index;
  assign frame.tick = state.tick;
  assign frame.rollover = state.rollover;

  ////////////////////////////////////////////////////////////////////////////
  a_index_step: assert property (@(posedge ref_clk) disable iff (!reset_n)
    frame.tick |-> frame.index == $past(frame.index) + INDEX_ONE)
    else $error("Index did not advance by one on a microframe tick.");

  a_tick_period: assert property (@(posedge ref_clk) disable iff (!reset_n)
    frame.tick ##1 (frame.run && !frame.load) [*2] |-> !frame.tick)
    else $error("Microframe ticks came too close together.");

  a_rollover_tick: assert property (@(posedge ref_clk) disable iff (!reset_n)
    frame.rollover |-> frame.tick && frame.index[ENTRY_LSB +: 3] == 3'h0)
    else $error("Rollover flagged away from a list wrap.");

  a_load_value: assert property (@(posedge ref_clk) disable iff (!reset_n)
    frame.load |=> frame.index == $past(frame.load_value) && !frame.tick)
    else $error("Loaded index value was not taken.");

  a_idle_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !frame.run && !frame.load |=> $stable(frame.index))
    else $error("Index moved while the schedule was stopped.");

endmodule // ehcii_frame_counter

// ===== tb/ehcii_status_model.sv
`timescale 1ns/10ps
module ehcii_status_model (
  input wire logic ref_clk, // System clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic [5:0] raise, // Source events, one pulse per bit.
  input wire logic [5:0] ack, // Software clears, one pulse per bit.
  input wire logic rollover_set, // Rollover event from the block.
  output logic [5:0] flags // Status flags seen by the block.
);
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags <= 6'h00;
    end else begin
      flags <= (flags & ~ack) | raise | {2'h0, rollover_set, 3'h0};
    end
  end
endmodule // ehcii_status_model

// ===== tb/ehcii_top_tb.sv
`timescale 1ns/10ps
module ehcii_top_tb import ehcii_pkg::*;;
  logic ref_clk, reset_n, reg_write, reg_read, reg_read_ack, halted_flag, run_stop;
  logic threshold_tick, host_irq, rollover_set, microframe_tick;
  logic [7:0] reg_addr;
  logic [3:0] reg_byte_en;
  logic [31:0] reg_wdata, reg_rdata, pre;
  logic [5:0] status_flags, raise, ack;
  logic [1:0] frame_list_size;
  logic [10:0] sof_frame_number;
  logic [9:0] frame_list_entry;
  int n_mismatch, samples_checked, i, nc;

  ehcii_top #(.MICROFRAME_LEN(8)) uut (.ref_clk(ref_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
    .reg_byte_en(reg_byte_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_read_ack(reg_read_ack), .status_flags(status_flags), .halted_flag(halted_flag),
    .run_stop(run_stop), .frame_list_size(frame_list_size),
    .threshold_tick(threshold_tick), .host_irq(host_irq), .rollover_set(rollover_set),
    .microframe_tick(microframe_tick), .sof_frame_number(sof_frame_number),
    .frame_list_entry(frame_list_entry));
  ehcii_status_model status_model (.ref_clk(ref_clk), .reset_n(reset_n), .raise(raise),
    .ack(ack), .rollover_set(rollover_set), .flags(status_flags));

  ////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_byte_en = be;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge ref_clk);
    reg_write = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(negedge ref_clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge ref_clk);
    reg_read = 1'b0;
    chk("read ack", 32'h1, {31'h0, reg_read_ack});
    chk(what, exp, reg_rdata);
  endtask
  // Counts rising edges until the next microframe tick, bounded.
  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (microframe_tick !== 1'b1 && n < 40);
  endtask
  task automatic pulse(input int which, input logic [5:0] v);
    @(negedge ref_clk);
    if (which == 0) raise = v;
    else ack = v;
    @(negedge ref_clk);
    raise = 6'h00;
    ack = 6'h00;
  endtask
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    #(8 * 20000);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    {reset_n, reg_write, reg_read, threshold_tick, run_stop} = 5'h00;
    {reg_addr, reg_byte_en, reg_wdata, raise, ack, frame_list_size} = 58'h0;
    halted_flag = 1'b1;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    reset_n = 1'b1;
    rd(IRQ_ENABLE_OFFSET, 32'h0, "enable reset");
    rd(FRAME_INDEX_OFFSET, 32'h0, "index reset");
    rd(8'h30, 32'h0, "unmapped read");
    wr(IRQ_ENABLE_OFFSET, 4'h1, 32'h3F);
    wr(IRQ_ENABLE_OFFSET, 4'h0, 32'h0);
    rd(IRQ_ENABLE_OFFSET, 32'h3F, "enable rw");
    $display("test registers done");
    for (i = 0; i < 6; i++) begin
      wr(IRQ_ENABLE_OFFSET, 4'h1, 32'h1 << i);
      pulse(0, 6'h01 << i);
      idle(3);
      if (THRESHOLD_SOURCES[i]) begin
        chk("irq before threshold", 32'h0, {31'h0, host_irq});
        threshold_tick = 1'b1;
        idle(1);
        threshold_tick = 1'b0;
        idle(2);
      end
      chk("irq enabled", 32'h1, {31'h0, host_irq});
      pulse(1, 6'h01 << i);
      idle(3);
      chk("irq cleared", 32'h0, {31'h0, host_irq});
    end
    wr(IRQ_ENABLE_OFFSET, 4'h1, 32'h0);
    pulse(0, 6'h3F);
    threshold_tick = 1'b1;
    idle(1);
    threshold_tick = 1'b0;
    idle(3);
    chk("irq disabled", 32'h0, {31'h0, host_irq});
    chk("flags polled", 32'h3F, {26'h0, status_flags});
    pulse(1, 6'h3F);
    $display("test interrupts done");
    wr(FRAME_INDEX_OFFSET, 4'hF, 32'h1234);
    rd(FRAME_INDEX_OFFSET, 32'h1234, "index write");
    chk("sof after write", 32'h246, {21'h0, sof_frame_number});
    wr(FRAME_INDEX_OFFSET, 4'h3, 32'h0055);
    halted_flag = 1'b0;
    wr(FRAME_INDEX_OFFSET, 4'hF, 32'h0);
    halted_flag = 1'b1;
    rd(FRAME_INDEX_OFFSET, 32'h1234, "index refused");
    for (i = 0; i < 3; i++) begin
      frame_list_size = 2'(i);
      pre = (32'h1 << (14 - i)) - 32'h1;
      wr(FRAME_INDEX_OFFSET, 4'hF, pre);
      chk("entry mask", (32'h1 << (10 - i)) - 32'h1, {22'h0, frame_list_entry});
      @(negedge ref_clk);
      halted_flag = 1'b0;
      run_stop = 1'b1;
      wait_tick(nc);
      chk("rollover pulse", 32'h1, {31'h0, rollover_set});
      chk("entry wrapped", 32'h0, {22'h0, frame_list_entry});
      chk("sof step", ((pre + 32'h1) & 32'h3FFF) >> 3, {21'h0, sof_frame_number});
      wait_tick(nc);
      chk("microframe period", 32'h8, 32'(nc));
      chk("no rollover", 32'h0, {31'h0, rollover_set});
      @(negedge ref_clk);
      run_stop = 1'b0;
      halted_flag = 1'b1;
      rd(FRAME_INDEX_OFFSET, (pre + 32'h2) & 32'h3FFF, "index count");
      chk("rollover flag", 32'h8, {26'h0, status_flags});
      pulse(1, 6'h08);
    end
    $display("test frame index done");
    end_of_test();
  end
endmodule // ehcii_top_tb
